/* pkg/threshold_params.svh */
// Constants for the measurement limit checker: offsets, fields, reset values
//
// Contract
// - The temperature upper comparison runs only while its check enable bit is 1.
// - A temperature code at or above the 12-bit upper limit (reset all ones) interrupts.
// - The temperature lower comparison runs only while its check enable bit is 1.
// - A temperature code at or below the 12-bit lower limit (reset zero) interrupts.
// - Auto-scan picks the checked temperature by sensor select, otherwise by mode field.
// - The first auxiliary upper comparison runs only while its enable bit is 1.
// - A first auxiliary code at or above its upper limit (reset all ones) interrupts.
// - The first auxiliary lower comparison runs only while its enable bit is 1.
// - A first auxiliary code at or below its lower limit (reset zero) interrupts.
// - The second auxiliary upper comparison runs only while its enable bit is 1.
// - A second auxiliary code at or above its upper limit (reset all ones) interrupts.
// - The second auxiliary lower comparison runs only while its enable bit is 1.
// - A second auxiliary code at or below its lower limit (reset zero) interrupts.
// - The read-only temperature upper flag shows whether the result is at or above the limit.
// - With pin one selected for interrupt, any failed limit check drives that pin.
`ifndef THRESHOLD_PARAMS_SVH
`define THRESHOLD_PARAMS_SVH

// ==========================================================
// Register offsets
`define LIM_ADDR_TEMP_UPPER 8'h06
`define LIM_ADDR_TEMP_LOWER 8'h07
`define LIM_ADDR_FIRST_AUXILIARY_INPUT_UPPER 8'h08
`define LIM_ADDR_FIRST_AUXILIARY_INPUT_LOWER 8'h09
`define LIM_ADDR_SECOND_AUXILIARY_INPUT_UPPER 8'h0a
`define LIM_ADDR_SECOND_AUXILIARY_INPUT_LOWER 8'h0b

// ==========================================================
// Field positions
`define LIM_ENABLE_BIT      12
`define LIM_VALUE_MSB       11

// ==========================================================
// Reset values
`define LIM_UPPER_RESET     12'hfff
`define LIM_LOWER_RESET     12'h000
`define LIM_ENABLE_RESET    1'b0

// ==========================================================
// Converter mode field codes that select a temperature input
`define MODE_FIRST_TEMPERATURE_MEASUREMENT          4'ha
`define MODE_SECOND_TEMPERATURE_MEASUREMENT          4'hc

`endif

/* pkg/threshold_pkg.sv */
// Types and shared functions for the measurement limit checker
`default_nettype none

package threshold_pkg;

    // Which measurement the converter just finished
    typedef enum logic [2:0] {
        CH_NONE  = 3'h0,
        CH_FIRST_TEMPERATURE_MEASUREMENT = 3'h1,
        CH_SECOND_TEMPERATURE_MEASUREMENT = 3'h2,
        CH_FIRST_AUXILIARY_INPUT  = 3'h3,
        CH_SECOND_AUXILIARY_INPUT  = 3'h4
    } conv_channel_t;

    typedef logic [11:0] code_t;

    // Upper limits trip on equal or above, lower on equal or below
    function automatic logic limit_crossed(input code_t code, input code_t limit,
                                           input logic upper);
        limit_crossed = upper ? (code >= limit) : (code <= limit);
    endfunction : limit_crossed

endpackage : threshold_pkg

`default_nettype wire

/* rtl/limit_register.sv */
// One limit register: check enable plus 12-bit limit value
`include "threshold_params.svh"
`default_nettype none

module limit_register
    import threshold_pkg::*;
#(
    parameter code_t RESET_LIMIT = `LIM_LOWER_RESET
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic [15:0] wdata,
    output logic             check_enable,
    output code_t            limit_value,
    output logic [15:0]      read_word
);

    logic  en_q, en_d;
    code_t lim_q, lim_d;

    // ==========================================================
    // Write path; bits above the enable are simply dropped
    always_comb begin
        en_d  = en_q;
        lim_d = lim_q;
        if (wr_en) begin
            en_d  = wdata[`LIM_ENABLE_BIT];
            lim_d = wdata[`LIM_VALUE_MSB:0];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            en_q  <= `LIM_ENABLE_RESET;
            lim_q <= RESET_LIMIT;
        end else begin
            en_q  <= en_d;
            lim_q <= lim_d;
        end
    end

    assign check_enable = en_q;
    assign limit_value  = lim_q;
    assign read_word    = {3'h0, en_q, lim_q};

endmodule : limit_register

`default_nettype wire

/* rtl/channel_limit_check.sv */
// Upper and lower limit judgement for one measurement channel
`default_nettype none

module channel_limit_check
    import threshold_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  sys_rst,
    input  wire logic  sample_valid,
    input  wire code_t sample_code,
    input  wire logic  upper_enable,
    input  wire code_t upper_limit,
    input  wire logic  lower_enable,
    input  wire code_t lower_limit,
    output logic       upper_flag,
    output logic       lower_flag,
    output logic       fail_pulse
);

    logic up_q, up_d, lo_q, lo_d, fail_q, fail_d;
    logic up_hit, lo_hit;

    // Comparisons only count while their enable is set
    assign up_hit = upper_enable && limit_crossed(sample_code, upper_limit, 1'b1);
    assign lo_hit = lower_enable && limit_crossed(sample_code, lower_limit, 1'b0);

    // ==========================================================
    // Flags refresh once per conversion; a disabled check drops its flag
    always_comb begin
        up_d   = upper_enable ? up_q : 1'b0;
        lo_d   = lower_enable ? lo_q : 1'b0;
        fail_d = 1'b0;
        if (sample_valid) begin
            up_d   = up_hit;
            lo_d   = lo_hit;
            fail_d = up_hit || lo_hit;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            up_q   <= 1'b0;
            lo_q   <= 1'b0;
            fail_q <= 1'b0;
        end else begin
            up_q   <= up_d;
            lo_q   <= lo_d;
            fail_q <= fail_d;
        end
    end

    assign upper_flag = up_q;
    assign lower_flag = lo_q;
    assign fail_pulse = fail_q;

endmodule : channel_limit_check

`default_nettype wire

/* rtl/measurement_threshold_checker.sv */
// Limit checker for temperature and auxiliary conversion results
`include "threshold_params.svh"
`default_nettype none

module measurement_threshold_checker
    import threshold_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          sys_rst,
    // Register port from the serial control decoder
    input  wire logic [7:0]    reg_addr,
    input  wire logic          reg_wr_en,
    input  wire logic [15:0]   reg_wdata,
    input  wire logic          reg_rd_en,
    output logic [15:0]        reg_rdata,
    output logic               reg_rd_valid,
    // Converter result stream
    input  wire logic          conv_done,
    input  wire conv_channel_t conv_channel,
    input  wire code_t         conv_code,
    // Measurement configuration held elsewhere
    input  wire logic          auto_scan_mode,
    input  wire logic          auto_temp_sensor_select,
    input  wire logic [3:0]    converter_mode_field,
    input  wire logic          pin_one_interrupt_select,
    // Flags and interrupt
    output logic               temp_upper_flag,
    output logic               temp_lower_flag,
    output logic               aux_one_upper_flag,
    output logic               aux_one_lower_flag,
    output logic               aux_two_upper_flag,
    output logic               aux_two_lower_flag,
    output logic               limit_fail_event,
    output logic               pin_one_interrupt
);

    // ==========================================================
    // Register decode
    logic       wr_temp_u, wr_temp_l;
    logic       wr_first_auxiliary_input_u, wr_first_auxiliary_input_l;
    logic       wr_second_auxiliary_input_u, wr_second_auxiliary_input_l;

    // Each write strobe reaches only the register at its own offset
    assign wr_temp_u = reg_wr_en && (reg_addr == `LIM_ADDR_TEMP_UPPER);
    assign wr_temp_l = reg_wr_en && (reg_addr == `LIM_ADDR_TEMP_LOWER);
    assign wr_first_auxiliary_input_u = reg_wr_en && (reg_addr == `LIM_ADDR_FIRST_AUXILIARY_INPUT_UPPER);
    assign wr_first_auxiliary_input_l = reg_wr_en && (reg_addr == `LIM_ADDR_FIRST_AUXILIARY_INPUT_LOWER);
    assign wr_second_auxiliary_input_u = reg_wr_en && (reg_addr == `LIM_ADDR_SECOND_AUXILIARY_INPUT_UPPER);
    assign wr_second_auxiliary_input_l = reg_wr_en && (reg_addr == `LIM_ADDR_SECOND_AUXILIARY_INPUT_LOWER);

    // ==========================================================
    // Limit registers
    logic        temp_upper_check_enable,    temp_lower_check_enable;
    logic        aux_one_upper_check_enable, aux_one_lower_check_enable;
    logic        aux_two_upper_check_enable, aux_two_lower_check_enable;
    code_t       temp_upper_limit_value,     temp_lower_limit_value;
    code_t       aux_upper_limit_value,      aux_one_lower_limit_value;
    code_t       aux_two_upper_limit_value,  aux_two_lower_limit_value;
    logic [15:0] word_temp_u, word_temp_l;
    logic [15:0] word_first_auxiliary_input_u, word_first_auxiliary_input_l;
    logic [15:0] word_second_auxiliary_input_u, word_second_auxiliary_input_l;

    // Upper limits wake at full scale so nothing trips before setup
    limit_register #(.RESET_LIMIT(`LIM_UPPER_RESET)) u_temp_upper (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_temp_u),
        .wdata        (reg_wdata),
        .check_enable (temp_upper_check_enable),
        .limit_value  (temp_upper_limit_value),
        .read_word    (word_temp_u)
    );

    limit_register #(.RESET_LIMIT(`LIM_LOWER_RESET)) u_temp_lower (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_temp_l),
        .wdata        (reg_wdata),
        .check_enable (temp_lower_check_enable),
        .limit_value  (temp_lower_limit_value),
        .read_word    (word_temp_l)
    );

    limit_register #(.RESET_LIMIT(`LIM_UPPER_RESET)) u_first_auxiliary_input_upper (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_first_auxiliary_input_u),
        .wdata        (reg_wdata),
        .check_enable (aux_one_upper_check_enable),
        .limit_value  (aux_upper_limit_value),
        .read_word    (word_first_auxiliary_input_u)
    );

    limit_register #(.RESET_LIMIT(`LIM_LOWER_RESET)) u_first_auxiliary_input_lower (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_first_auxiliary_input_l),
        .wdata        (reg_wdata),
        .check_enable (aux_one_lower_check_enable),
        .limit_value  (aux_one_lower_limit_value),
        .read_word    (word_first_auxiliary_input_l)
    );

    limit_register #(.RESET_LIMIT(`LIM_UPPER_RESET)) u_second_auxiliary_input_upper (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_second_auxiliary_input_u),
        .wdata        (reg_wdata),
        .check_enable (aux_two_upper_check_enable),
        .limit_value  (aux_two_upper_limit_value),
        .read_word    (word_second_auxiliary_input_u)
    );

    limit_register #(.RESET_LIMIT(`LIM_LOWER_RESET)) u_second_auxiliary_input_lower (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .wr_en        (wr_second_auxiliary_input_l),
        .wdata        (reg_wdata),
        .check_enable (aux_two_lower_check_enable),
        .limit_value  (aux_two_lower_limit_value),
        .read_word    (word_second_auxiliary_input_l)
    );

    // ==========================================================
    // Read path; one cycle latency, unmapped offsets answer zero
    logic [15:0] rdata_q, rdata_d;
    logic        rd_valid_q, rd_valid_d;

    always_comb begin
        rdata_d    = rdata_q;
        rd_valid_d = reg_rd_en;
        if (reg_rd_en) begin
            case (reg_addr)
                `LIM_ADDR_TEMP_UPPER: rdata_d = word_temp_u;
                `LIM_ADDR_TEMP_LOWER: rdata_d = word_temp_l;
                `LIM_ADDR_FIRST_AUXILIARY_INPUT_UPPER: rdata_d = word_first_auxiliary_input_u;
                `LIM_ADDR_FIRST_AUXILIARY_INPUT_LOWER: rdata_d = word_first_auxiliary_input_l;
                `LIM_ADDR_SECOND_AUXILIARY_INPUT_UPPER: rdata_d = word_second_auxiliary_input_u;
                `LIM_ADDR_SECOND_AUXILIARY_INPUT_LOWER: rdata_d = word_second_auxiliary_input_l;
                default:              rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q    <= 16'h0000;
            rd_valid_q <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            rd_valid_q <= rd_valid_d;
        end
    end

    assign reg_rdata    = rdata_q;
    assign reg_rd_valid = rd_valid_q;

    // ==========================================================
    // Which temperature result the limits apply to
    logic want_first_temperature_measurement, want_second_temperature_measurement;
    logic temp_sample, first_auxiliary_input_sample, second_auxiliary_input_sample;

    // Auto-scan follows the sensor select; manual runs follow the mode field
    always_comb begin
        if (auto_scan_mode) begin
            want_first_temperature_measurement = !auto_temp_sensor_select;
            want_second_temperature_measurement = auto_temp_sensor_select;
        end else begin
            want_first_temperature_measurement = (converter_mode_field == `MODE_FIRST_TEMPERATURE_MEASUREMENT);
            want_second_temperature_measurement = (converter_mode_field == `MODE_SECOND_TEMPERATURE_MEASUREMENT);
        end
    end

    // One judgement per finished conversion of the matching input
    assign temp_sample = conv_done
                       && (((conv_channel == CH_FIRST_TEMPERATURE_MEASUREMENT) && want_first_temperature_measurement)
                        || ((conv_channel == CH_SECOND_TEMPERATURE_MEASUREMENT) && want_second_temperature_measurement));
    assign first_auxiliary_input_sample = conv_done && (conv_channel == CH_FIRST_AUXILIARY_INPUT);
    assign second_auxiliary_input_sample = conv_done && (conv_channel == CH_SECOND_AUXILIARY_INPUT);

    // ==========================================================
    // Channel checkers; limits are sampled live at the conversion edge
    logic temp_fail, first_auxiliary_input_fail, second_auxiliary_input_fail;

    channel_limit_check u_temp_check (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_valid (temp_sample),
        .sample_code  (conv_code),
        .upper_enable (temp_upper_check_enable),
        .upper_limit  (temp_upper_limit_value),
        .lower_enable (temp_lower_check_enable),
        .lower_limit  (temp_lower_limit_value),
        .upper_flag   (temp_upper_flag),
        .lower_flag   (temp_lower_flag),
        .fail_pulse   (temp_fail)
    );

    channel_limit_check u_first_auxiliary_input_check (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_valid (first_auxiliary_input_sample),
        .sample_code  (conv_code),
        .upper_enable (aux_one_upper_check_enable),
        .upper_limit  (aux_upper_limit_value),
        .lower_enable (aux_one_lower_check_enable),
        .lower_limit  (aux_one_lower_limit_value),
        .upper_flag   (aux_one_upper_flag),
        .lower_flag   (aux_one_lower_flag),
        .fail_pulse   (first_auxiliary_input_fail)
    );

    channel_limit_check u_second_auxiliary_input_check (
        .clk          (clk),
        .sys_rst      (sys_rst),
        .sample_valid (second_auxiliary_input_sample),
        .sample_code  (conv_code),
        .upper_enable (aux_two_upper_check_enable),
        .upper_limit  (aux_two_upper_limit_value),
        .lower_enable (aux_two_lower_check_enable),
        .lower_limit  (aux_two_lower_limit_value),
        .upper_flag   (aux_two_upper_flag),
        .lower_flag   (aux_two_lower_flag),
        .fail_pulse   (second_auxiliary_input_fail)
    );

    // ==========================================================
    // Interrupt outputs
    logic any_flag;
    logic pin_q, pin_d;

    assign any_flag = temp_upper_flag || temp_lower_flag
                   || aux_one_upper_flag || aux_one_lower_flag
                   || aux_two_upper_flag || aux_two_lower_flag;

    // Event fires on each failing conversion, even if the flag was already up
    assign limit_fail_event = temp_fail || first_auxiliary_input_fail || second_auxiliary_input_fail;

    // Pin holds while any check is failing; level so a slow host cannot miss it
    always_comb begin
        pin_d = pin_one_interrupt_select && any_flag;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign pin_one_interrupt = pin_q;

endmodule : measurement_threshold_checker

`default_nettype wire

/* testbench/threshold_monitor.sv */
// Port-level checker for the measurement limit checker
`default_nettype none

module threshold_monitor
    import threshold_pkg::*;
(
    input wire logic          clk,
    input wire logic          sys_rst,
    input wire logic          reg_rd_en,
    input wire logic [15:0]   reg_rdata,
    input wire logic          reg_rd_valid,
    input wire logic          conv_done,
    input wire conv_channel_t conv_channel,
    input wire logic          pin_one_interrupt_select,
    input wire logic          temp_upper_flag,
    input wire logic          temp_lower_flag,
    input wire logic          aux_one_upper_flag,
    input wire logic          aux_one_lower_flag,
    input wire logic          aux_two_upper_flag,
    input wire logic          aux_two_lower_flag,
    input wire logic          limit_fail_event,
    input wire logic          pin_one_interrupt
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Failure that must reach the pin while it stays selected
    sequence fail_sel_s;
        limit_fail_event && pin_one_interrupt_select ##1 pin_one_interrupt_select;
    endsequence
    sequence quiet_sel_s;
        !pin_one_interrupt_select ##1 !pin_one_interrupt_select;
    endsequence

    rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read strobe got no valid");
    rd_cause_a: assert property (reg_rd_valid |-> $past(reg_rd_en))
        else $error("valid without a read");
    rsvd_zero_a: assert property (reg_rd_valid |-> reg_rdata[15:13] == 3'h0)
        else $error("reserved bits read nonzero");
    rdata_hold_a: assert property (!reg_rd_valid |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    event_cause_a: assert property (limit_fail_event |-> $past(conv_done))
        else $error("event without a conversion");
    event_flag_a: assert property (limit_fail_event |-> (temp_upper_flag || temp_lower_flag
        || aux_one_upper_flag || aux_one_lower_flag || aux_two_upper_flag
        || aux_two_lower_flag))
        else $error("event with no flag set");
    temp_src_a: assert property ($rose(temp_upper_flag) |-> $past(conv_done) && ($past(
        conv_channel) inside {conv_channel_t'(3'h1), conv_channel_t'(3'h2)}))
        else $error("temperature flag set by another channel");
    aux_one_src_a: assert property ($rose(aux_one_upper_flag) |->
        $past(conv_done && conv_channel == conv_channel_t'(3'h3)))
        else $error("first auxiliary flag set by another channel");
    aux_two_src_a: assert property ($rose(aux_two_lower_flag) |->
        $past(conv_done && conv_channel == conv_channel_t'(3'h4)))
        else $error("second auxiliary flag set by another channel");
    pin_raise_a: assert property (fail_sel_s |-> pin_one_interrupt)
        else $error("failure missed the interrupt pin");
    pin_quiet_a: assert property (quiet_sel_s |-> !pin_one_interrupt)
        else $error("pin active while not selected");
endmodule : threshold_monitor

bind measurement_threshold_checker threshold_monitor u_mon (.clk, .sys_rst, .reg_rd_en,
    .reg_rdata, .reg_rd_valid, .conv_done, .conv_channel, .pin_one_interrupt_select,
    .temp_upper_flag, .temp_lower_flag, .aux_one_upper_flag, .aux_one_lower_flag,
    .aux_two_upper_flag, .aux_two_lower_flag, .limit_fail_event, .pin_one_interrupt);

`default_nettype wire

/* testbench/host_port_model.sv */
// Host side of the register port: single-word reads and writes
`default_nettype none

module host_port_model (
    input  wire logic        clk,
    output logic [7:0]       reg_addr,
    output logic             reg_wr_en,
    output logic [15:0]      reg_wdata,
    output logic             reg_rd_en,
    input  wire logic [15:0] reg_rdata,
    input  wire logic        reg_rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    // ==========================================================
    // Idle bus
    initial begin
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd_en = 1'b0;
    end

    // ==========================================================
    // Accesses; released lines show inverted data so stale values never match
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr_en = 1'b1;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : write_word

    task automatic read_word(input logic [7:0] a, output logic [15:0] d);
        int n;
        n = 0;
        @(negedge clk);
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clk);
        reg_rd_en = 1'b0;
        reg_addr = ~a;
        // Bounded wait in case valid never comes
        while (reg_rd_valid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = reg_rdata;
    endtask : read_word
endmodule : host_port_model

`default_nettype wire

/* testbench/measurement_threshold_checker_tb_top.sv */
// Directed testbench for the measurement limit checker
`default_nettype none

module measurement_threshold_checker_tb_top
    import threshold_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic          clk = 1'b0;
    logic          sys_rst = 1'b1;
    wire  [7:0]    reg_addr;
    wire           reg_wr_en;
    wire  [15:0]   reg_wdata;
    wire           reg_rd_en;
    logic [15:0]   reg_rdata;
    logic          reg_rd_valid;
    logic          conv_done = 1'b0;
    conv_channel_t conv_channel = conv_channel_t'(3'h0);
    code_t         conv_code = 12'h000;
    logic          auto_scan_mode = 1'b0;
    logic          auto_temp_sensor_select = 1'b0;
    logic [3:0]    converter_mode_field = 4'ha;
    logic          pin_sel = 1'b0;
    logic          temp_upper_flag, temp_lower_flag, aux_one_upper_flag;
    logic          aux_one_lower_flag, aux_two_upper_flag, aux_two_lower_flag;
    logic          limit_fail_event, pin_one_interrupt;
    logic [5:0]    flags;
    int            err_total = 0;
    int            cmp_count = 0;
    logic [7:0]    ua;
    logic [2:0]    ch;
    logic [5:0]    fu, fl;

    assign flags = {temp_upper_flag, temp_lower_flag, aux_one_upper_flag,
                    aux_one_lower_flag, aux_two_upper_flag, aux_two_lower_flag};

    // ==========================================================
    // Clock, design and host
    always #12.5 clk = ~clk;

    measurement_threshold_checker uut (.clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wdata,
        .reg_rd_en, .reg_rdata, .reg_rd_valid, .conv_done, .conv_channel, .conv_code,
        .auto_scan_mode, .auto_temp_sensor_select, .converter_mode_field,
        .pin_one_interrupt_select(pin_sel), .temp_upper_flag, .temp_lower_flag,
        .aux_one_upper_flag, .aux_one_lower_flag, .aux_two_upper_flag,
        .aux_two_lower_flag, .limit_fail_event, .pin_one_interrupt);

    host_port_model host (.clk, .reg_addr, .reg_wr_en, .reg_wdata, .reg_rd_en,
        .reg_rdata, .reg_rd_valid);

    // ==========================================================
    // Compare and helper tasks
    task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic [5:0] got, input logic [5:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_flag

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] d;
        host.read_word(a, d);
        cmp_word(d, exp);
    endtask : chk_rd

    // One conversion: flags and event one cycle on, pin one cycle later
    task automatic conv(input logic [2:0] c, input code_t code, input logic [5:0] exp_f,
                        input logic exp_e);
        @(negedge clk);
        conv_done = 1'b1;
        conv_channel = conv_channel_t'(c);
        conv_code = code;
        @(negedge clk);
        conv_done = 1'b0;
        conv_channel = conv_channel_t'(3'h0);
        conv_code = ~code;
        cmp_flag(flags, exp_f);
        cmp_flag({5'h00, limit_fail_event}, {5'h00, exp_e});
        @(negedge clk);
        if (exp_e)
            cmp_flag({5'h00, pin_one_interrupt}, {5'h00, pin_sel});
    endtask : conv

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up

    // ==========================================================
    // Watchdog, far beyond the roughly 135 cycles the tests need
    initial begin
        #(25 * 4000);
        err_total++;
        wrap_up();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (6) @(negedge clk);
        sys_rst = 1'b0;
        for (int k = 0; k < 6; k++) begin
            chk_rd(8'h06 + 8'(k), k[0] ? 16'h0000 : 16'h0fff);
        end
        $display("test reset values done");
        host.write_word(8'h08, 16'hffff);
        chk_rd(8'h08, 16'h1fff);
        host.write_word(8'h05, 16'hffff);
        chk_rd(8'h05, 16'h0000);
        chk_rd(8'h0c, 16'h0000);
        $display("test reserved bits done");
        // Same sequence for temperature, first and second auxiliary
        for (int k = 0; k < 3; k++) begin
            ua = 8'h06 + 8'(2 * k);
            ch = (k == 0) ? 3'h1 : 3'(k + 2);
            fu = 6'h20 >> (2 * k);
            fl = 6'h10 >> (2 * k);
            host.write_word(ua, 16'h1800);
            host.write_word(ua + 8'h01, 16'h1100);
            conv(ch, 12'h800, fu, 1'b1);
            conv(ch, 12'h7ff, 6'h00, 1'b0);
            conv(ch, 12'h100, fl, 1'b1);
            conv(ch, 12'h101, 6'h00, 1'b0);
            host.write_word(ua, 16'h0800);
            conv(ch, 12'hfff, 6'h00, 1'b0);
            host.write_word(ua + 8'h01, 16'h0100);
            conv(ch, 12'h000, 6'h00, 1'b0);
        end
        chk_rd(8'h0b, 16'h0100);
        $display("test limit checks done");
        pin_sel = 1'b1;
        host.write_word(8'h06, 16'h1800);
        auto_scan_mode = 1'b1;
        auto_temp_sensor_select = 1'b1;
        conv(3'h1, 12'hfff, 6'h00, 1'b0);
        conv(3'h2, 12'hfff, 6'h20, 1'b1);
        auto_temp_sensor_select = 1'b0;
        conv(3'h2, 12'h000, 6'h20, 1'b0);
        conv(3'h1, 12'h000, 6'h00, 1'b0);
        auto_scan_mode = 1'b0;
        converter_mode_field = 4'hc;
        conv(3'h2, 12'h900, 6'h20, 1'b1);
        converter_mode_field = 4'h3;
        conv(3'h2, 12'h000, 6'h20, 1'b0);
        conv(3'h1, 12'h000, 6'h20, 1'b0);
        $display("test temperature select done");
        // Reset again in mid-run: limits and flags return to their defaults
        sys_rst = 1'b1;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        cmp_flag(flags, 6'h00);
        chk_rd(8'h06, 16'h0fff);
        $display("test second reset done");
        wrap_up();
    end
endmodule : measurement_threshold_checker_tb_top

`default_nettype wire
